// [src/mci_map.svh]
// offsets, widths, limits and counts of the motion command interpreter
// assumes the includer wants plain macros; no logic lives here
`ifndef MCI_MAP_SVH
`define MCI_MAP_SVH
`define PGM_DEPTH   16
`define PC_W        4
`define PC_LAST     4'hF
`define LBL_W       6
`define DIN_W       8
`define DOUT_W      4
`define PIN_W       15
`define SEL_LSB     8
`define SEL_MSB     13
`define START_BIT   14
`define ANGLE_W     16
// load angle in hundredths of a degree: 1,8 degrees
`define LOAD_ANGLE_LIMIT 16'h00B4
`endif

// [src/mci_pkg.sv]
// types shared by the motion command interpreter
// assumes mci_map.svh is on the include path
`include "mci_map.svh"
package mci_pkg;
  // instruction opcodes
  typedef enum logic [3:0] {
    OP_NOP, OP_CUR_ON, OP_CUR_OFF, OP_SET_VEL, OP_SET_TGT, OP_EXEC, OP_STOP,
    OP_POS_Q, OP_LABEL, OP_WAIT, OP_OUT, OP_IF, OP_GOTO, OP_HOME, OP_RETURN
  } op_t;
  // one decoded command; eol marks the last command of a program line
  typedef struct packed {
    op_t         op;
    logic [2:0]  sel;
    logic        lvl;
    logic        eol;
    logic [31:0] arg;
  } instr_t;
  // orders to the motion core
  typedef struct packed {
    logic        current;
    logic        start;
    logic        home;
    logic        stop;
    logic [1:0]  vel_units;
    logic [31:0] vel;
    logic [31:0] target;
  } motion_cmd_t;
  // interpreter states
  typedef enum logic [2:0] {
    ST_IDLE, ST_EXEC, ST_SEEK, ST_SKIP, ST_SETTLE, ST_WAIT_MOT
  } st_t;
  // all state of the interpreter
  typedef struct packed {
    st_t                          st;
    logic [`PC_W-1:0]             pc;
    logic [`LBL_W-1:0]            seek;
    logic                         single;
    instr_t                       cmd;
    logic [`PIN_W-1:0]            s1;
    logic [`PIN_W-1:0]            s2;
    logic [`PIN_W-1:0]            s3;
    logic [`PIN_W-1:0]            pins_q;
    logic                         start_q;
    instr_t [`PGM_DEPTH-1:0]      mem;
    logic [31:0]                  tgt;
    motion_cmd_t                  mv;
    logic [`DOUT_W-1:0]           dout;
    logic                         pos_v;
    logic                         pos_f;
    logic                         closed;
  } state_t;
endpackage

// [src/motion_command_interpreter.sv]
// motion command interpreter: runs serial commands and stored programs
// assumes a motion core that raises i_busy within one cycle of a start
`timescale 1ns/1ns
`include "mci_map.svh"
module motion_command_interpreter (
  // clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_b,
  // serial command port, already decoded
  input  wire logic                  i_cmd_valid,
  input  wire mci_pkg::instr_t       i_cmd,
  output logic                       o_cmd_ready,
  // program store load port
  input  wire logic                  i_pgm_we,
  input  wire logic [3:0]            i_pgm_addr,
  input  wire mci_pkg::instr_t       i_pgm_data,
  input  wire logic                  i_run,
  // pins: digital inputs, program select, program start
  input  wire logic [14:0]           i_pins,
  output logic [3:0]                 o_dout,
  // motion core
  output mci_pkg::motion_cmd_t       o_mv,
  input  wire logic                  i_busy,
  input  wire logic                  i_at_target,
  input  wire logic                  i_abs_mode,
  input  wire logic [1:0]            i_scale,
  input  wire logic [31:0]           i_act_pos,
  // load angle supervision
  input  wire logic                  i_closed_opt,
  input  wire logic [15:0]           i_load_angle,
  output logic                       o_closed_loop,
  // position query answer and status
  output logic                       o_pos_valid,
  output logic                       o_pos_flag,
  output logic                       o_prog_busy
);
  import mci_pkg::*;

  state_t s;       // registered state
  state_t next_s;  // next state
  instr_t ins;     // command being executed

  // true when synced input sel stands at level lvl
  function automatic logic din_match(input logic [`PIN_W-1:0] p,
                                     input logic [2:0] sel, input logic lvl);
    din_match = (p[sel] == lvl);
  endfunction

  // current command comes from the serial port or the program store
  always_comb begin
    ins = s.single ? s.cmd : s.mem[s.pc];
  end

  // next state
  always_comb begin
    next_s          = s;
    next_s.mv.start = 1'b0;
    next_s.mv.home  = 1'b0;
    next_s.mv.stop  = 1'b0;
    next_s.pos_v    = 1'b0;
    // pin synchroniser; a bit moves once stages two and three agree
    next_s.s1 = i_pins;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    for (int i = 0; i < `PIN_W; i++) begin
      if (s.s2[i] == s.s3[i]) begin
        next_s.pins_q[i] = s.s3[i];
      end
    end
    next_s.start_q = s.pins_q[`START_BIT];
    // program store write
    if (i_pgm_we) begin
      next_s.mem[i_pgm_addr] = i_pgm_data;
    end
    // open loop below the limit or without the option, closed loop with the option at or above
    next_s.closed = i_closed_opt && (i_load_angle >= `LOAD_ANGLE_LIMIT);
    case (s.st)
      // idle: accept a serial command or start a program
      ST_IDLE: begin
        if (s.pins_q[`START_BIT] && !s.start_q) begin
          next_s.seek   = s.pins_q[`SEL_MSB:`SEL_LSB];
          next_s.pc     = '0;
          next_s.single = 1'b0;
          next_s.st     = ST_SEEK;
        end else if (i_run) begin
          next_s.pc     = '0;
          next_s.single = 1'b0;
          next_s.st     = ST_EXEC;
        end else if (i_cmd_valid) begin
          next_s.cmd    = i_cmd;
          next_s.single = 1'b1;
          next_s.st     = ST_EXEC;
        end
      end
      // execute one command, then move on in line order
      ST_EXEC: begin
        // default: step to the next command
        if (s.single || s.pc == `PC_LAST) begin
          next_s.st = ST_IDLE;
        end else begin
          next_s.pc = s.pc + 1'b1;
        end
        case (ins.op)
          OP_CUR_ON:  next_s.mv.current = 1'b1;
          OP_CUR_OFF: next_s.mv.current = 1'b0;
          OP_SET_VEL: begin
            next_s.mv.vel       = ins.arg;
            next_s.mv.vel_units = i_scale;
          end
          OP_SET_TGT: next_s.tgt = ins.arg;
          OP_EXEC: begin
            next_s.mv.start  = 1'b1;
            next_s.mv.target = i_abs_mode ? s.tgt : s.tgt + i_act_pos;
            // at the last index nothing follows; waiting would rerun the move
            if (!s.single && s.pc != `PC_LAST) begin
              next_s.st = ST_SETTLE;
            end
          end
          OP_HOME: begin
            next_s.mv.home = 1'b1;
            if (!s.single && s.pc != `PC_LAST) begin
              next_s.st = ST_SETTLE;
            end
          end
          OP_STOP: next_s.mv.stop = 1'b1;
          OP_POS_Q: begin
            next_s.pos_v = 1'b1;
            next_s.pos_f = i_at_target && !i_busy;
          end
          OP_OUT: next_s.dout[ins.sel[1:0]] = ins.lvl;
          OP_WAIT: begin
            // hold the same command until the input matches; ignored as a single command
            if (!din_match(s.pins_q, ins.sel, ins.lvl) && !s.single) begin
              next_s.pc = s.pc;
              next_s.st = ST_EXEC;
            end
          end
          OP_IF: begin
            // false: drop the rest of the line
            if (!din_match(s.pins_q, ins.sel, ins.lvl) && !s.single) begin
              next_s.st = ST_SKIP;
            end
          end
          OP_GOTO: begin
            if (!s.single) begin
              next_s.seek = ins.arg[`LBL_W-1:0];
              next_s.pc   = '0;
              next_s.st   = ST_SEEK;
            end
          end
          OP_RETURN: next_s.st = ST_IDLE;
          default: begin
          end
        endcase
      end
      // scan the store for the label; give up at the end
      ST_SEEK: begin
        if (s.mem[s.pc].op == OP_LABEL && s.mem[s.pc].arg[`LBL_W-1:0] == s.seek) begin
          next_s.st = ST_EXEC;
        end else if (s.pc == `PC_LAST) begin
          next_s.st = ST_IDLE;
        end else begin
          next_s.pc = s.pc + 1'b1;
        end
      end
      // skip up to and including the end of the line
      ST_SKIP: begin
        if (s.pc == `PC_LAST) begin
          next_s.st = ST_IDLE;
        end else begin
          next_s.pc = s.pc + 1'b1;
          if (s.mem[s.pc].eol) begin
            next_s.st = ST_EXEC;
          end
        end
      end
      // give the motion core one cycle to raise busy
      ST_SETTLE: next_s.st = ST_WAIT_MOT;
      // continue the line once movement has stopped
      ST_WAIT_MOT: begin
        if (!i_busy) begin
          next_s.st = ST_EXEC;
        end
      end
      default: next_s.st = ST_IDLE;
    endcase
  end

  // state register with synchronous reset
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // outputs
  assign o_cmd_ready   = (s.st == ST_IDLE);
  assign o_dout        = s.dout;
  assign o_mv          = s.mv;
  assign o_closed_loop = s.closed;
  assign o_pos_valid   = s.pos_v;
  assign o_pos_flag    = s.pos_f;
  assign o_prog_busy   = (s.st != ST_IDLE);

  // helper terms for checks
  logic in_exec;
  assign in_exec = (s.st == ST_EXEC);
  logic                stop_exec;  // a stop command executes this cycle
  logic                reached;    // motion core reports the target reached
  logic [31:0]         rel_tgt;    // relative target from stored value and position
  logic [`LBL_W-1:0]   prog_sel;   // program number on the synced pins
  assign stop_exec = in_exec && (ins.op == OP_STOP);
  assign reached   = i_at_target && !i_busy;
  assign rel_tgt   = s.tgt + i_act_pos;
  assign prog_sel  = s.pins_q[`SEL_MSB:`SEL_LSB];

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  property p_cur_on;
    in_exec && ins.op == OP_CUR_ON |=> o_mv.current;
  endproperty
  a_cur_on: assert property (p_cur_on) else $error("current not on");

  property p_cur_off;
    in_exec && ins.op == OP_CUR_OFF |=> !o_mv.current;
  endproperty
  a_cur_off: assert property (p_cur_off) else $error("current not off");

  property p_vel;
    in_exec && ins.op == OP_SET_VEL |=> o_mv.vel == $past(ins.arg);
  endproperty
  a_vel: assert property (p_vel) else $error("velocity not set");

  property p_exec_abs;
    in_exec && ins.op == OP_EXEC && i_abs_mode |=> o_mv.start && o_mv.target == $past(s.tgt);
  endproperty
  a_exec_abs: assert property (p_exec_abs) else $error("positioning not started");

  property p_pos;
    in_exec && ins.op == OP_POS_Q |=> o_pos_valid && o_pos_flag == $past(reached);
  endproperty
  a_pos: assert property (p_pos) else $error("bad position reply");

  property p_wait;
    in_exec && !s.single && ins.op == OP_WAIT && !din_match(s.pins_q, ins.sel, ins.lvl)
      |=> in_exec && $stable(s.pc);
  endproperty
  a_wait: assert property (p_wait) else $error("wait did not hold");

  property p_out;
    in_exec && ins.op == OP_OUT |=> o_dout[$past(ins.sel[1:0])] == $past(ins.lvl);
  endproperty
  a_out: assert property (p_out) else $error("output not driven");

  property p_if;
    in_exec && !s.single && ins.op == OP_IF && !din_match(s.pins_q, ins.sel, ins.lvl)
      |=> s.st == ST_SKIP;
  endproperty
  a_if: assert property (p_if) else $error("false condition not skipped");

  property p_goto;
    in_exec && !s.single && ins.op == OP_GOTO |=> s.st == ST_SEEK && s.pc == '0;
  endproperty
  a_goto: assert property (p_goto) else $error("jump not taken");

  sequence q_move_issued;
    in_exec && !s.single && s.pc != `PC_LAST && (ins.op == OP_EXEC || ins.op == OP_HOME);
  endsequence
  sequence q_hold_line;
    s.st == ST_SETTLE ##1 s.st == ST_WAIT_MOT;
  endsequence
  property p_move_wait;
    q_move_issued |=> q_hold_line;
  endproperty
  a_move_wait: assert property (p_move_wait) else $error("line went on during move");

  property p_home;
    in_exec && ins.op == OP_HOME |=> o_mv.home;
  endproperty
  a_home: assert property (p_home) else $error("homing not started");

  property p_return;
    in_exec && ins.op == OP_RETURN |=> o_cmd_ready;
  endproperty
  a_return: assert property (p_return) else $error("return did not end");

  property p_closed;
    i_closed_opt && i_load_angle >= `LOAD_ANGLE_LIMIT |=> o_closed_loop;
  endproperty
  a_closed: assert property (p_closed) else $error("closed loop not entered");

  // the pulse ends unless a further stop command follows at once
  property p_stop;
    stop_exec |=> o_mv.stop ##1 (!o_mv.stop || $past(stop_exec));
  endproperty
  a_stop: assert property (p_stop) else $error("stop not pulsed");

  property p_tgt;
    in_exec && ins.op == OP_SET_TGT |=> s.tgt == $past(ins.arg);
  endproperty
  a_tgt: assert property (p_tgt) else $error("target not stored");

  // relative mode: the move goes the stored distance from the actual position
  property p_exec_rel;
    in_exec && ins.op == OP_EXEC && !i_abs_mode
      |=> o_mv.start && o_mv.target == $past(rel_tgt);
  endproperty
  a_exec_rel: assert property (p_exec_rel) else $error("relative move wrong");

  // plain commands of a program step to the next index
  property p_line_order;
    in_exec && !s.single && s.pc != `PC_LAST
      && ins.op inside {OP_CUR_ON, OP_CUR_OFF, OP_SET_VEL, OP_SET_TGT, OP_OUT}
      |=> in_exec && s.pc == $past(s.pc) + 1'b1;
  endproperty
  a_line_order: assert property (p_line_order) else $error("line order broken");

  // a start edge on the pins seeks the selected program number
  property p_prog_sel;
    o_cmd_ready && s.pins_q[`START_BIT] && !s.start_q
      |=> s.st == ST_SEEK && s.seek == $past(prog_sel);
  endproperty
  a_prog_sel: assert property (p_prog_sel) else $error("program not selected");

endmodule

// [test/motion_command_interpreter_tb.sv]
// bench of the motion command interpreter: serial commands, programs, load angle
// assumes the motion core model on the far side and a 250 MHz clock
`timescale 1ns/1ns
`include "mci_map.svh"
module motion_command_interpreter_tb;
  import mci_pkg::*;
  logic        clk, rst_b, cmd_valid, cmd_ready, pgm_we, run, busy, at_tgt;
  logic        abs_mode, closed_opt, closed_loop, pos_valid, pos_flag, prog_busy;
  logic [3:0]  pgm_addr, dout;
  logic [1:0]  scale;
  logic [14:0] pins;
  logic [15:0] angle, rnd;
  logic [31:0] act_pos, a;
  instr_t      cmd, pgm_data;
  motion_cmd_t mv;
  int          error_cnt, cmp_count;
  // design under test and its motion core
  motion_command_interpreter dut (.i_clk(clk), .i_rst_b(rst_b), .i_cmd_valid(cmd_valid),
    .i_cmd(cmd), .o_cmd_ready(cmd_ready), .i_pgm_we(pgm_we), .i_pgm_addr(pgm_addr),
    .i_pgm_data(pgm_data), .i_run(run), .i_pins(pins), .o_dout(dout), .o_mv(mv),
    .i_busy(busy), .i_at_target(at_tgt), .i_abs_mode(abs_mode), .i_scale(scale),
    .i_act_pos(act_pos), .i_closed_opt(closed_opt), .i_load_angle(angle),
    .o_closed_loop(closed_loop), .o_pos_valid(pos_valid), .o_pos_flag(pos_flag),
    .o_prog_busy(prog_busy));
  motion_core_model #(.LEN(12)) core (.i_clk(clk), .i_rst_b(rst_b), .i_mv(mv),
    .o_busy(busy), .o_at_target(at_tgt));
  // clock: 4 ns period
  always #2 clk = ~clk;
  // random source: shift register seeded with 83
  function automatic logic [15:0] nxt(input logic [15:0] r);
    return {r[14:0], r[15] ^ r[13] ^ r[12] ^ r[10]};
  endfunction
  // builds one command word
  function automatic instr_t mk(op_t o, logic [2:0] s, logic l, logic e, logic [31:0] g);
    return '{op: o, sel: s, lvl: l, eol: e, arg: g};
  endfunction
  // conditions waited for, by number
  function automatic logic flag(input int k);
    case (k)
      0: return mv.start;
      1: return dout[1];
      2: return !dout[1];
      3: return !prog_busy;
      4: return mv.home;
      5: return dout[0];
      default: return !busy;
    endcase
  endfunction
  // compares one value and counts it
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  // waits a bounded time for a condition, then checks it
  task automatic await_cond(input int k);
    for (int i = 0; i < 300 && flag(k) !== 1'b1; i++) @(negedge clk);
    chk("wait", 1, flag(k));
  endtask
  // one serial command; returns where its effect can be seen
  task automatic put(input op_t o, input logic [31:0] g);
    @(negedge clk);
    chk("ready", 1, cmd_ready);
    cmd = mk(o, 3'h0, 1'b0, 1'b1, g);
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    @(negedge clk);
  endtask
  // writes one program store word
  task automatic load(input int ad, input op_t o, input int s, input logic l, input logic e,
                      input int g);
    @(negedge clk);
    pgm_we = 1'b1;
    pgm_addr = ad[3:0];
    pgm_data = mk(o, s[2:0], l, e, g);
    @(negedge clk);
    pgm_we = 1'b0;
  endtask
  // prints the counts and the verdict, then stops
  task automatic tally_and_finish();
    $display("mismatches %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // watchdog against a hang: the run needs under a thousand cycles, this allows 25000
  initial begin
    #100000;
    error_cnt++;
    tally_and_finish();
  end
  // main sequence
  initial begin
    {clk, cmd_valid, pgm_we, run, closed_opt, scale, pgm_addr, pins, angle, act_pos} = '0;
    {cmd, pgm_data} = '0;
    {rst_b, abs_mode} = 2'b01;
    rnd = 16'h0053;
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    chk("mv", 0, mv.current);
    put(OP_CUR_ON, 0);
    chk("current", 1, mv.current);
    put(OP_CUR_OFF, 0);
    chk("current", 0, mv.current);
    // velocity in scalings 0 to 2, random values
    for (int i = 0; i < 3; i++) begin
      rnd = nxt(rnd);
      scale = i[1:0];
      put(OP_SET_VEL, {rnd, 16'h03E8});
      chk("vel", {rnd, 16'h03E8}, mv.vel);
      chk("units", i, mv.vel_units);
    end
    rnd = nxt(rnd);
    put(OP_SET_TGT, rnd);
    put(OP_EXEC, 0);
    chk("start", 1, mv.start);
    chk("target", rnd, mv.target);
    put(OP_POS_Q, 0);
    chk("pos", 2'b10, {pos_valid, pos_flag});
    await_cond(6);
    put(OP_POS_Q, 0);
    chk("pos", 2'b11, {pos_valid, pos_flag});
    // relative move adds the actual position
    abs_mode = 1'b0;
    act_pos = {nxt(rnd), rnd};
    put(OP_SET_TGT, 32'h64);
    put(OP_EXEC, 0);
    chk("target", act_pos + 32'h64, mv.target);
    put(OP_STOP, 0);
    chk("stop", 1, mv.stop);
    abs_mode = 1'b1;
    // load angle just below, at and above the limit, and option absent
    for (int j = 0; j < 4; j++) begin
      a = (j == 0) ? `LOAD_ANGLE_LIMIT - 1 : (j == 2) ? 16'hFFFF : `LOAD_ANGLE_LIMIT;
      closed_opt = (j != 3);
      angle = a[15:0];
      repeat (3) @(negedge clk);
      chk("closed", closed_opt && a >= `LOAD_ANGLE_LIMIT, closed_loop);
    end
    // stored program: wait, outputs, target then execute, false condition, jump, return
    load(0, OP_LABEL, 0, 0, 1, 1);
    load(1, OP_WAIT, 0, 1, 1, 0);
    load(2, OP_OUT, 1, 1, 1, 0);
    load(3, OP_SET_TGT, 0, 0, 0, 55);
    load(4, OP_EXEC, 0, 0, 0, 0);
    load(5, OP_OUT, 1, 0, 1, 0);
    load(6, OP_IF, 2, 1, 0, 0);
    load(7, OP_OUT, 0, 1, 1, 0);
    load(8, OP_GOTO, 0, 0, 1, 2);
    load(9, OP_OUT, 2, 1, 1, 0);
    load(10, OP_LABEL, 0, 0, 0, 2);
    load(11, OP_OUT, 3, 1, 0, 0);
    load(12, OP_RETURN, 0, 0, 1, 0);
    load(13, OP_LABEL, 0, 0, 0, 5);
    load(14, OP_HOME, 0, 0, 0, 0);
    load(15, OP_OUT, 0, 1, 1, 0);
    @(negedge clk);
    run = 1'b1;
    @(negedge clk);
    run = 1'b0;
    repeat (10) @(negedge clk);
    chk("held", 5'h10, {prog_busy, dout});
    pins[0] = 1'b1;
    await_cond(1);
    await_cond(0);
    chk("target", 55, mv.target);
    chk("dout", 1, dout[1]);
    await_cond(2);
    chk("busy", 0, busy);
    await_cond(3);
    chk("dout", 4'h8, dout);
    // parallel start of subprogram five
    pins[13:8] = 6'h05;
    pins[14] = 1'b1;
    await_cond(4);
    chk("dout", 0, dout[0]);
    await_cond(5);
    chk("busy", 0, busy);
    pins[14] = 1'b0;
    await_cond(3);
    tally_and_finish();
  end
endmodule

// [test/motion_core_model.sv]
// motion core stand-in: travels for a fixed time after a start or home order
// assumes orders arrive as one-cycle pulses on the interpreter's o_mv
`timescale 1ns/1ns
module motion_core_model #(parameter int LEN = 12) (
  // clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_rst_b,
  // orders in, status out
  input  wire mci_pkg::motion_cmd_t i_mv,
  output logic                      o_busy,
  output logic                      o_at_target
);
  import mci_pkg::*;
  int cnt; // cycles of travel left
  // busy rises on the edge after an order; stop cuts travel short
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      cnt <= 0;
      o_busy <= 1'b0;
      o_at_target <= 1'b0;
    end else if (i_mv.start || i_mv.home) begin
      cnt <= LEN;
      o_busy <= 1'b1;
      o_at_target <= 1'b0;
    end else if (i_mv.stop) begin
      cnt <= 0;
      o_busy <= 1'b0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else if (o_busy) begin
      // travel over: target reached
      cnt <= 0;
      o_busy <= 1'b0;
      o_at_target <= 1'b1;
    end
  end
endmodule
